// >>> core/hgl_limiter.sv
// Headroom gain limiter: per-sample attenuation, AHB-Lite settings.
// Assumes one sample per in_valid cycle and supply_level in fsp units.
//
// What this block does
// - Kind high with knee 0dBFS gives only the fixed level limiter.
// - Fixed limiter is infinite ratio; threshold 0 to -15dBFS by field.
// - Fixed limit voltage is full-scale peak times 10^(threshold/20).
// - Below threshold pass; above it attenuate by threshold minus input level.
// - Fixed limit caps output alike whatever the supply level.
// - Compressor knee 0 to -15dBFS by field, fixed against input scale.
// - Compressor threshold voltage is full-scale peak times 10^(knee/20).
// - Ratio is knee over target attenuation minus knee; below knee pass.
// - Above knee attenuation is target minus input times target over knee.
// - Combined: compress first, then hard limit; no limit above target.
// - Begin pulse when attenuation first starts.
// - End pulse when attenuation is fully released.
// - No pulse while attenuation moves between nonzero levels.
// - Ceiling field selects maximum attenuation -1dB to -15dB in 1dB.
// - Attenuation beyond ceiling is clamped at the ceiling.
// - Target attenuation clamped at 0dB; never any positive gain.
// - Margin offsets supply from +20% to -20% in 2.5% steps.
// - Kind low, the default, tracks the target peak as threshold.
`timescale 1ns/100ps
`include "hgl_defs.svh"
module hgl_limiter #(
  parameter int SW = 24,
  parameter int SUPW = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic in_valid,
  input wire logic [SW-1:0] in_sample,
  input wire logic [SUPW-1:0] supply_level,
  output logic out_valid,
  output logic [SW-1:0] out_sample,
  output logic gain_reduction_active,
  output logic gain_reduction_begin_irq,
  output logic gain_reduction_end_irq
);
  if (SW < 8 || SW > 24) begin : g_chk_sw
    $error("hgl_limiter: SW out of range");
  end
  if (SUPW != 16) begin : g_chk_sup
    $error("hgl_limiter: SUPW must match the full-scale peak width");
  end

  localparam int TW = SUPW + 1;

  localparam hgl_pkg::hgl_cfg_type CFG_RST = '{
    margin: 5'sh00,
    ceiling: `HGL_CEIL_RST,
    knee: 4'h0,
    thr: 4'h0,
    kind: 1'b0
  };

  localparam hgl_pkg::hgl_state_type ST_RST = '{
    cfg: CFG_RST,
    fsp: `HGL_FSP_RST,
    wr_pend: 1'b0,
    wr_idx: 2'h0,
    hrdata: 32'h0000_0000,
    out_valid: 1'b0,
    out_data: 32'h0000_0000,
    att: 14'sh0000,
    active: 1'b0,
    bgn: 1'b0,
    fin: 1'b0
  };

  hgl_pkg::hgl_state_type st_r;
  hgl_pkg::hgl_state_type st_nxt;

  logic [SW-2:0] in_mag;
  logic [TW-1:0] target_peak;
  hgl_pkg::hgl_db_type lvl_in;
  hgl_pkg::hgl_db_type lvl_tgt;
  hgl_pkg::hgl_db_type lvl_fsp;
  hgl_pkg::hgl_db_type atpo;
  hgl_pkg::hgl_db_type att_calc;
  hgl_pkg::hgl_db_type ratio_q4;
  logic [15:0] gain;
  logic signed [SW+16:0] prod;

  // Input magnitude, the most negative code saturates
  always_comb begin
    if (!in_sample[SW-1]) begin
      in_mag = in_sample[SW-2:0];
    end else if (in_sample[SW-2:0] == '0) begin
      in_mag = '1;
    end else begin
      in_mag = (~in_sample[SW-2:0]) + 1'b1;
    end
  end

  // Target peak from supply with margin
  always_comb begin
    int m;
    int t;
    m = int'(st_r.cfg.margin);
    t = 0;
    if (m > `HGL_MARGIN_MAX) begin
      m = `HGL_MARGIN_MAX;
    end
    if (m < -`HGL_MARGIN_MAX) begin
      m = -`HGL_MARGIN_MAX;
    end
    t = int'(supply_level) * (`HGL_MARGIN_DEN - m) / `HGL_MARGIN_DEN;
    target_peak = TW'(t);
  end

  hgl_level_db #(
    .W(SW - 1)
  ) u_lvl_in (
    .mag(in_mag),
    .level(lvl_in)
  );

  hgl_level_db #(
    .W(TW)
  ) u_lvl_tgt (
    .mag(target_peak),
    .level(lvl_tgt)
  );

  hgl_level_db #(
    .W(TW)
  ) u_lvl_fsp (
    .mag({1'b0, st_r.fsp}),
    .level(lvl_fsp)
  );

  // Target attenuation, never above 0dB
  always_comb begin
    int a;
    a = int'(lvl_tgt) - int'(lvl_fsp);
    if (a > 0) begin
      a = 0;
    end
    atpo = hgl_pkg::hgl_db_type'(a);
  end

  // Per-sample attenuation demand of all functions
  always_comb begin
    int lv;
    int thr_db;
    int knee_db;
    int lim;
    int drc;
    int tot;
    int ceil_code;
    int amax;
    lv = int'(lvl_in);
    thr_db = 0;
    knee_db = -int'(st_r.cfg.knee) * `HGL_Q_PER_DB;
    lim = 0;
    drc = 0;
    tot = 0;
    ceil_code = int'(st_r.cfg.ceiling);
    amax = 0;
    if (st_r.cfg.kind) begin
      thr_db = -int'(st_r.cfg.thr) * `HGL_Q_PER_DB;
    end else begin
      thr_db = int'(atpo);
    end
    if (lv > thr_db) begin
      lim = thr_db - lv;
    end
    if (st_r.cfg.knee != 4'h0 && lv > knee_db) begin
      // Zero knee bypasses the compressor
      drc = int'(atpo) * (lv - knee_db) / (-knee_db);
    end
    // Limit on compressed output equals the most negative demand
    tot = (drc < lim) ? drc : lim;
    if (tot > 0) begin
      tot = 0;
    end
    if (ceil_code == 0) begin
      ceil_code = 1;
    end
    amax = -ceil_code * `HGL_Q_PER_DB;
    if (tot < amax) begin
      tot = amax;
    end
    att_calc = hgl_pkg::hgl_db_type'(tot);
  end

  // Present compression ratio in sixteenths, zero when undefined
  always_comb begin
    int knee_db;
    int den;
    knee_db = -int'(st_r.cfg.knee) * `HGL_Q_PER_DB;
    den = int'(atpo) - knee_db;
    if (st_r.cfg.knee == 4'h0 || den == 0) begin
      ratio_q4 = 14'sh0000;
    end else begin
      ratio_q4 = hgl_pkg::hgl_db_type'(knee_db * `HGL_Q_PER_DB / den);
    end
  end

  hgl_db_gain u_gain (
    .att(att_calc),
    .gain(gain)
  );

  assign prod = $signed(in_sample) * $signed({1'b0, gain});

  // Next state: bus slave and sample path
  always_comb begin
    logic addr_ok;
    logic att_nz;
    logic [31:0] rd;
    st_nxt = st_r;
    addr_ok = (haddr[31:4] == 28'h0000000);
    att_nz = 1'b0;
    rd = 32'h0000_0000;
    st_nxt.bgn = 1'b0;
    st_nxt.fin = 1'b0;
    st_nxt.out_valid = 1'b0;

    // Data phase of a write
    if (st_r.wr_pend) begin
      case (st_r.wr_idx)
        `HGL_IDX_CTRL: begin
          st_nxt.cfg.kind = hwdata[`HGL_KIND_BIT];
          st_nxt.cfg.thr = hwdata[`HGL_THR_LSB +: 4];
          st_nxt.cfg.knee = hwdata[`HGL_KNEE_LSB +: 4];
          st_nxt.cfg.ceiling = hwdata[`HGL_CEIL_LSB +: 4];
          st_nxt.cfg.margin = hwdata[`HGL_MARGIN_LSB +: 5];
        end
        `HGL_IDX_FSP: begin
          st_nxt.fsp = hwdata[15:0];
        end
        default: begin
          st_nxt.fsp = st_r.fsp;
        end
      endcase
    end

    // Address phase
    st_nxt.wr_pend = 1'b0;
    if (hsel && htrans[1] && hready) begin
      st_nxt.wr_pend = hwrite && addr_ok && (hsize == 3'h2);
      st_nxt.wr_idx = haddr[3:2];
      if (!hwrite && addr_ok) begin
        case (haddr[3:2])
          `HGL_IDX_CTRL: begin
            rd[`HGL_KIND_BIT] = st_r.cfg.kind;
            rd[`HGL_THR_LSB +: 4] = st_r.cfg.thr;
            rd[`HGL_KNEE_LSB +: 4] = st_r.cfg.knee;
            rd[`HGL_CEIL_LSB +: 4] = st_r.cfg.ceiling;
            rd[`HGL_MARGIN_LSB +: 5] = st_r.cfg.margin;
          end
          `HGL_IDX_FSP: begin
            rd[15:0] = st_r.fsp;
          end
          `HGL_IDX_STATUS: begin
            rd[`HGL_STAT_ACT_BIT] = st_r.active;
            rd[`HGL_STAT_ATT_LSB +: 14] = st_r.att;
          end
          `HGL_IDX_TARGET: begin
            rd[13:0] = atpo;
            rd[`HGL_TGT_RATIO_LSB +: 14] = ratio_q4;
          end
          default: begin
            rd = 32'h0000_0000;
          end
        endcase
      end
      st_nxt.hrdata = rd;
    end

    // Sample path
    if (in_valid) begin
      st_nxt.out_valid = 1'b1;
      st_nxt.out_data = 32'(prod >>> 15);
      st_nxt.att = att_calc;
      att_nz = (att_calc != 14'sh0000);
      st_nxt.active = att_nz;
      // Edges of activity only, level changes stay silent
      st_nxt.bgn = att_nz && !st_r.active;
      st_nxt.fin = !att_nz && st_r.active;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_r.hrdata;
  assign out_valid = st_r.out_valid;
  assign out_sample = st_r.out_data[SW-1:0];
  assign gain_reduction_active = st_r.active;
  assign gain_reduction_begin_irq = st_r.bgn;
  assign gain_reduction_end_irq = st_r.fin;
endmodule

// >>> include/hgl_defs.svh
// Constants of the headroom gain limiter: offsets, fields, resets, scalings.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef HGL_DEFS_SVH
`define HGL_DEFS_SVH
`define HGL_IDX_CTRL 2'h0
`define HGL_IDX_FSP 2'h1
`define HGL_IDX_STATUS 2'h2
`define HGL_IDX_TARGET 2'h3
`define HGL_KIND_BIT 0
`define HGL_THR_LSB 4
`define HGL_KNEE_LSB 8
`define HGL_CEIL_LSB 12
`define HGL_MARGIN_LSB 16
`define HGL_STAT_ACT_BIT 0
`define HGL_STAT_ATT_LSB 16
`define HGL_TGT_RATIO_LSB 16
`define HGL_CEIL_RST 4'hF
`define HGL_FSP_RST 16'h8000
`define HGL_MARGIN_MAX 8
`define HGL_MARGIN_DEN 40
`define HGL_Q_PER_DB 16
`define HGL_LOG_MUL 385
`define HGL_LOG_SHR 6
`define HGL_EXP_MUL 170
`define HGL_EXP_SHR 14
`define HGL_EXP_CORR 11
`define HGL_EXP_CSHR 19
`define HGL_LOG_CORR 11
`define HGL_LOG_CSHR 9
`define HGL_DB_FLOOR 14'h2001
`define HGL_UNITY_Q15 32768
`endif

// >>> include/hgl_pkg.sv
// Types of the headroom gain limiter: level in dB, settings, module state.
// Assumes hgl_defs.svh is on the include path.
`include "hgl_defs.svh"
package hgl_pkg;
  // Level or attenuation in sixteenths of a dB, zero is full scale
  typedef logic signed [13:0] hgl_db_type;

  typedef struct packed {
    logic signed [4:0] margin;
    logic [3:0] ceiling;
    logic [3:0] knee;
    logic [3:0] thr;
    logic kind;
  } hgl_cfg_type;

  typedef struct packed {
    hgl_cfg_type cfg;
    logic [15:0] fsp;
    logic wr_pend;
    logic [1:0] wr_idx;
    logic [31:0] hrdata;
    logic out_valid;
    logic [31:0] out_data;
    hgl_db_type att;
    logic active;
    logic bgn;
    logic fin;
  } hgl_state_type;
endpackage

// >>> core/hgl_level_db.sv
// Magnitude to level converter, dB below full scale of a W-bit magnitude.
// Assumes an unsigned magnitude; zero maps to the lowest level.
`timescale 1ns/100ps
`include "hgl_defs.svh"
module hgl_level_db #(
  parameter int W = 23
) (
  input wire logic [W-1:0] mag,
  output hgl_pkg::hgl_db_type level
);
  if (W < 5 || W > 31) begin : g_chk
    $error("hgl_level_db: W out of range");
  end

  always_comb begin
    int msb;
    int l2;
    int d;
    int m;
    logic [W-1:0] norm;
    msb = -1;
    l2 = 0;
    d = 0;
    m = 0;
    norm = '0;
    for (int i = 0; i < W; i++) begin
      if (mag[i]) begin
        msb = i;
      end
    end
    if (msb < 0) begin
      level = `HGL_DB_FLOOR;
    end else begin
      // Leading one plus four mantissa bits gives log2 in sixteenths
      norm = mag << (W - 1 - msb);
      m = int'(norm[W-2 -: 4]);
      // Parabolic term lifts the linear mantissa toward log2
      m = m + ((m * (`HGL_Q_PER_DB - m) * `HGL_LOG_CORR) >>> `HGL_LOG_CSHR);
      l2 = msb * `HGL_Q_PER_DB + m - W * `HGL_Q_PER_DB;
      d = (l2 * `HGL_LOG_MUL) >>> `HGL_LOG_SHR;
      level = hgl_pkg::hgl_db_type'(d);
    end
  end
endmodule

// >>> core/hgl_db_gain.sv
// Attenuation in dB to linear gain, unity being 32768.
// Assumes the attenuation is zero or negative.
`timescale 1ns/100ps
`include "hgl_defs.svh"
module hgl_db_gain (
  input hgl_pkg::hgl_db_type att,
  output logic [15:0] gain
);
  always_comb begin
    int l2;
    int n;
    int f;
    int c;
    l2 = -int'(att) * `HGL_EXP_MUL;
    n = l2 >>> `HGL_EXP_SHR;
    f = l2 & ((1 << `HGL_EXP_SHR) - 1);
    // Parabolic term pulls the linear mantissa down toward 2^-x
    c = (f * ((1 << `HGL_EXP_SHR) - f) * `HGL_EXP_CORR) >>> `HGL_EXP_CSHR;
    if (l2 <= 0) begin
      gain = 16'h8000;
    end else if (n > 15) begin
      gain = 16'h0000;
    end else begin
      // Whole octaves by shift, fraction by linear mantissa
      gain = 16'((`HGL_UNITY_Q15 - f - c) >>> n);
    end
  end
endmodule

// >>> verification/hgl_limiter_checker.sv
// Checker of the limiter ports: sample timing, events and gain.
// Assumes a bind onto hgl_limiter, one clock and synchronous reset.
`timescale 1ns/100ps
module hgl_limiter_checker #(
  parameter int SW = 24
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  input wire logic [SW-1:0] in_sample,
  input wire logic out_valid,
  input wire logic [SW-1:0] out_sample,
  input wire logic gain_reduction_active,
  input wire logic gain_reduction_begin_irq,
  input wire logic gain_reduction_end_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  function automatic logic [SW-1:0] mag(logic [SW-1:0] v);
    return v[SW-1] ? -v : v;
  endfunction
  property p_valid; in_valid |=> out_valid; endproperty
  a_valid: assert property (p_valid) else $error("missing output sample");
  property p_novalid; !in_valid |=> !out_valid; endproperty
  a_novalid: assert property (p_novalid) else $error("stray output sample");
  property p_pass;
    out_valid && !gain_reduction_active |-> out_sample == $past(in_sample);
  endproperty
  a_pass: assert property (p_pass) else $error("idle sample altered");
  property p_hold;
    $past(rst_b) && !out_valid |-> $stable(out_sample) && $stable(gain_reduction_active);
  endproperty
  a_hold: assert property (p_hold) else $error("output changed between samples");
  property p_rose; $rose(gain_reduction_active) |-> gain_reduction_begin_irq; endproperty
  a_rose: assert property (p_rose) else $error("begin pulse missing");
  property p_fell;
    $past(rst_b) && $fell(gain_reduction_active) |-> gain_reduction_end_irq;
  endproperty
  a_fell: assert property (p_fell) else $error("end pulse missing");
  property p_bgn; gain_reduction_begin_irq |-> $rose(gain_reduction_active); endproperty
  a_bgn: assert property (p_bgn) else $error("stray begin pulse");
  property p_fin; gain_reduction_end_irq |-> $fell(gain_reduction_active); endproperty
  a_fin: assert property (p_fin) else $error("stray end pulse");
  property p_gain; out_valid |-> mag(out_sample) <= mag($past(in_sample)); endproperty
  a_gain: assert property (p_gain) else $error("positive gain seen");
  c_bgn: cover property (gain_reduction_begin_irq);
  c_fin: cover property (gain_reduction_end_irq);
  c_pass: cover property (out_valid && !gain_reduction_active);
endmodule

bind hgl_limiter hgl_limiter_checker #(.SW(SW)) i_chk (
  .clk(clk), .rst_b(rst_b), .in_valid(in_valid), .in_sample(in_sample),
  .out_valid(out_valid), .out_sample(out_sample),
  .gain_reduction_active(gain_reduction_active),
  .gain_reduction_begin_irq(gain_reduction_begin_irq),
  .gain_reduction_end_irq(gain_reduction_end_irq)
);

// >>> verification/hgl_src_model.sv
// Upstream sample path and supply converter model.
// Assumes the bench calls its tasks; outputs change just after clk rises.
`timescale 1ns/100ps
module hgl_src_model #(
  parameter int SW = 24
) (
  input wire logic clk,
  output logic in_valid,
  output logic [SW-1:0] in_sample,
  output logic [15:0] supply_level
);
  initial begin
    in_valid = 1'b0;
    in_sample = '0;
    supply_level = 16'hFFFF;
  end
  task automatic set_supply(input logic [15:0] v);
    @(posedge clk);
    supply_level <= v;
  endtask
  // One strobed sample; junk on the bus between samples
  task automatic send(input logic [SW-1:0] s);
    @(posedge clk);
    in_valid <= 1'b1;
    in_sample <= s;
    @(posedge clk);
    in_valid <= 1'b0;
    in_sample <= ~s;
  endtask
endmodule

// >>> verification/hgl_limiter_bench.sv
// Bench of the headroom gain limiter: register access and sample checks.
// Assumes hgl_src_model as sample source and the bound checker.
`timescale 1ns/100ps
module hgl_limiter_bench;
  localparam logic [23:0] FS = 24'h7FFFFF;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic hready, hresp, out_valid, act, bgn, fin, in_valid;
  logic [31:0] hrdata;
  logic [23:0] in_sample, out_sample, o;
  logic [15:0] supply_level;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  initial forever #5 clk = ~clk;
  hgl_src_model i_src (.clk(clk), .in_valid(in_valid), .in_sample(in_sample),
    .supply_level(supply_level));
  hgl_limiter i_dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .in_valid(in_valid), .in_sample(in_sample), .supply_level(supply_level),
    .out_valid(out_valid), .out_sample(out_sample), .gain_reduction_active(act),
    .gain_reduction_begin_irq(bgn), .gain_reduction_end_irq(fin));
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Level within about 1 dB of the input scaled by db
  task automatic chk_db(input logic [23:0] got, input logic [23:0] in, input real db);
    real e;
    e = real'(in) * 10.0 ** (db / 20.0);
    compares++;
    if ($isunknown(got) || real'(got) < e * 0.89 || real'(got) > e * 1.12) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, int'(e));
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic smp(input logic [23:0] s);
    i_src.send(s);
    #1;
    o = out_sample;
    chk({31'h0, out_valid}, 32'h1);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd(32'h0, 32'h0000F000);
    rd(32'h4, 32'h00008000);
    wr(32'h10, 32'hFFFFFFFF);
    rd(32'h10, 32'h0);
    smp(FS);
    chk({8'h0, o}, {8'h0, FS});
    i_src.set_supply(16'h4000);
    smp(FS);
    chk_db(o, FS, -6.02);
    wr(32'h0, 32'h0008F000);
    i_src.set_supply(16'h8000);
    smp(FS);
    chk_db(o, FS, -1.94);
    wr(32'h0, 32'h0000F061);
    smp(24'h100000);
    chk({7'h0, act, o}, 32'h00100000);
    smp(FS);
    chk({30'h0, bgn, fin}, 32'h2);
    chk_db(o, FS, -6.0);
    i_src.set_supply(16'h6000);
    smp(24'h600000);
    chk({30'h0, bgn, fin}, 32'h0);
    chk_db(o, 24'h600000, -3.5);
    smp(24'h100000);
    chk({30'h0, bgn, fin}, 32'h1);
    for (int c = 1; c < 16; c++) begin
      wr(32'h0, 32'h000000F1 | (c << 12));
      smp(FS);
      chk_db(o, FS, -real'(c));
    end
    i_src.set_supply(16'h4000);
    wr(32'h0, 32'h0000F601);
    smp(24'h200000);
    chk({8'h0, o}, 32'h00200000);
    smp(24'h5A9DF7);
    chk_db(o, 24'h5A9DF7, -3.0);
    wr(32'h0, 32'h0000F631);
    smp(FS);
    chk_db(o, FS, -6.02);
    i_src.set_supply(16'hFFFF);
    smp(FS);
    chk_db(o, FS, -3.0);
    end_sim();
  end
endmodule
